// *** icps_link_if.sv ***
// Two-wire link between the configuration master and the slave port
`timescale 1ns/1ps
`default_nettype none
interface icps_link_if;
   logic scl_o;        // Master clock drive (open drain low)
   logic scl_oe;
   logic sda_m_o;      // Master data
   logic sda_m_oe;
   logic sda_s_o;      // Slave data
   logic sda_s_oe;
   logic scl;          // Resolved clock line
   logic sda;          // Resolved data line
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
   modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
   modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface : icps_link_if
`default_nettype wire

// *** icps_link_monitor.sv ***
// Checker for the two-wire link between the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module icps_link_monitor
   import icps_pkg::*;
(
   input  wire logic sys_clk_i,  // 20 MHz clock
   input  wire logic rst_n_i,    // Sync reset, active low
   input  wire logic sda_m_oe,   // Master data enable
   input  wire logic sda_s_o,    // Slave data
   input  wire logic sda_s_oe,   // Slave data enable
   input  wire logic scl,        // Resolved clock line
   input  wire logic sda         // Resolved data line
);
   import icps_pkg::*;
   logic [7:0] hi_cnt_q, hi_cnt_d, lo_cnt_q, lo_cnt_d;
   logic       slave_low;
   assign slave_low = sda_s_oe && !sda_s_o;
   ////////////////////////////////////////////////////////////////////////////////
   // Run lengths of the clock line, saturating
   always_comb begin
      hi_cnt_d = (!scl) ? 8'h00 : ((hi_cnt_q == 8'hFF) ? hi_cnt_q : hi_cnt_q + 8'h01);
      lo_cnt_d = scl ? 8'h00 : ((lo_cnt_q == 8'hFF) ? lo_cnt_q : lo_cnt_q + 8'h01);
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         hi_cnt_q <= 8'h00;
         lo_cnt_q <= 8'h00;
      end else begin
         hi_cnt_q <= hi_cnt_d;
         lo_cnt_q <= lo_cnt_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_ack_held;
      slave_low throughout (1'b1 ##[1:40] $rose(scl));
   endsequence
   sequence s_ack_release;
      ##[1:80] !slave_low;
   endsequence
   a_slave_data_steady: assert property (scl && $past(scl) |-> $stable(slave_low))
      else $error("slave data moved while clock high");
   a_reset_idle_lines: assert property ($rose(rst_n_i) |-> scl && sda && !sda_m_oe && !sda_s_oe)
      else $error("link not idle after reset");
   a_scl_high_min: assert property ($fell(scl) |-> hi_cnt_q >= SCL_HALF_CYC)
      else $error("clock high phase too short");
   a_scl_low_min: assert property ($rose(scl) |-> lo_cnt_q >= SCL_HALF_CYC)
      else $error("clock low phase too short");
   a_start_slave_off: assert property ($fell(sda) && scl && $past(scl) |-> !slave_low)
      else $error("slave pulled data at start");
   a_ack_in_low: assert property ($rose(slave_low) |-> !scl && !$past(scl))
      else $error("slave ack began outside clock low");
   a_ack_held_high: assert property ($rose(slave_low) |-> s_ack_held)
      else $error("slave ack not held to clock rise");
   a_ack_released: assert property ($rose(slave_low) |-> s_ack_release)
      else $error("slave ack not released");
endmodule : icps_link_monitor
`default_nettype wire

// *** icps_master.sv ***
// Two-wire bus master end with APB command registers
`timescale 1ns/1ps
`default_nettype none
module icps_master
   import icps_pkg::*;
(
   input  wire logic        sys_clk_i,   // 20 MHz clock
   input  wire logic        rst_n_i,     // Sync reset, active low
   icps_link_if.master      link,        // Two-wire link
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [3:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic [31:0]      prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr      // APB error
);
   import icps_pkg::*;
   // 0x0 CMD: [7:0] offset,[8] rd,[9] go(w) busy(r),[10] nack(r),[11] addr lsb
   // 0x4 DATA: write byte, reads back the byte last written
   typedef enum logic [3:0] {M_IDLE, M_START, M_BIT, M_STOP, M_DONE} icps_mst_t;
   icps_mst_t   st_q, st_d;
   logic [7:0]  half_q, half_d;
   logic [5:0]  ph_q, ph_d;          // bit phase within sequence
   logic [26:0] seq_q, seq_d;        // bits to emit, MSB first
   logic [11:0] cmd_q, cmd_d;
   logic [7:0]  dat_q, dat_d;
   logic        scl_q, scl_d, sda_q, sda_d, sdaoe_q, sdaoe_d, nack_q, nack_d;
   logic [31:0] prd_q, prd_d;
   logic        rdy_q, rdy_d;
   logic        tick;
   assign tick = (half_q == 8'h00);
   always_comb begin
      st_d = st_q; half_d = tick ? SCL_HALF_CNT : half_q - 8'h01;
      ph_d = ph_q; seq_d = seq_q;
      cmd_d = cmd_q; dat_d = dat_q; scl_d = scl_q; sda_d = sda_q;
      sdaoe_d = sdaoe_q; nack_d = nack_q; prd_d = 32'h0; rdy_d = 1'b0;
      if (psel && penable && !rdy_q) begin
         rdy_d = 1'b1;
         if (pwrite && paddr == 4'h0 && st_q == M_IDLE) begin
            cmd_d = {pwdata[11], 1'b0, 1'b1, pwdata[8:0]};
            st_d  = M_START;
         end else if (pwrite && paddr == 4'h4) dat_d = pwdata[7:0];
         else if (!pwrite) prd_d = (paddr == 4'h0) ? {20'h0, cmd_q} : {24'h0, dat_q};
      end
      cmd_d[9] = (st_q != M_IDLE) || cmd_d[9] && st_d != M_IDLE;
      cmd_d[10] = nack_q;
      if (tick) begin
         unique case (st_q)
            M_IDLE: begin scl_d = 1'b1; sdaoe_d = 1'b0; ph_d = 6'h0; end
            M_START: begin
               sdaoe_d = 1'b1; sda_d = 1'b0; st_d = M_BIT; ph_d = 6'h0; nack_d = 1'b0;
               // Write: addr,ack,offset,ack,data,ack. Read: addr,ack,offset,ack,stop
               seq_d = {DEV_ADDR_HI, cmd_q[11], 1'b0, 1'b1, cmd_q[7:0], 1'b1,
                        dat_q, 1'b1};
            end
            M_BIT: begin
               scl_d = !scl_q;
               // Slot count advances on each clock rise
               ph_d  = scl_q ? ph_q : ph_q + 6'h1;
               if (scl_q) begin
                  if (ph_q == 6'd27 || (cmd_q[8] && ph_q == 6'd18)) begin
                     st_d = M_STOP; sdaoe_d = 1'b1; sda_d = 1'b0;
                  end else begin
                     sda_d = seq_q[26 - ph_q];
                     sdaoe_d = !(ph_q == 6'd8 || ph_q == 6'd17 || ph_q == 6'd26);
                  end
               end else if (ph_q == 6'd8 || ph_q == 6'd17 || ph_q == 6'd26) begin
                  nack_d = nack_q | link.sda;
               end
            end
            M_STOP: begin
               if (!scl_q) scl_d = 1'b1;
               else begin sdaoe_d = 1'b0; st_d = M_DONE; end
            end
            M_DONE: st_d = M_IDLE;
            default: st_d = M_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_q <= M_IDLE; half_q <= 8'h00; ph_q <= 6'h0; seq_q <= 27'h0;
         cmd_q <= 12'h000; dat_q <= 8'h00; scl_q <= 1'b1;
         sda_q <= 1'b1; sdaoe_q <= 1'b0; nack_q <= 1'b0; prd_q <= 32'h0; rdy_q <= 1'b0;
      end else begin
         st_q <= st_d; half_q <= half_d; ph_q <= ph_d; seq_q <= seq_d;
         cmd_q <= cmd_d;
         dat_q <= dat_d; scl_q <= scl_d; sda_q <= sda_d; sdaoe_q <= sdaoe_d;
         nack_q <= nack_d; prd_q <= prd_d; rdy_q <= rdy_d;
      end
   end
   assign link.scl_o    = scl_q;
   assign link.scl_oe   = 1'b1;
   assign link.sda_m_o  = sda_q;
   assign link.sda_m_oe = sdaoe_q && !sda_q;
   assign prdata  = prd_q;
   assign pready  = rdy_q;
   assign pslverr = 1'b0;
endmodule : icps_master
`default_nettype wire

// *** icps_pkg.sv ***
// Package for the two-wire configuration port: map, fields, resets, protocol constants
package icps_pkg;
   localparam logic [5:0] DEV_ADDR_HI       = 6'h36;    // 110110
   localparam logic [7:0] OFS_INPUT_SELECT  = 8'h00;
   localparam logic [7:0] OFS_BANK_POWER    = 8'h01;
   localparam int         NUM_REGS          = 16;
   localparam logic [7:0] RST_INPUT_SELECT  = 8'h00;
   localparam logic [7:0] RST_BANK_POWER    = 8'h00;
   // Fields of input_select_control
   localparam int         BIT_SWITCH_MODE   = 7;
   localparam int         BIT_REF_SEL_HI    = 6;
   localparam int         BIT_REF_SEL_LO    = 5;
   localparam int         BIT_SEL_SOURCE    = 4;
   localparam int         BIT_DIV_SYNC      = 0;
   localparam logic [7:0] MASK_INPUT_SELECT = 8'hF1;
   // Fields of bank_power_enable_control
   localparam int         BIT_BANK_A_VOLT   = 7;
   localparam int         BIT_BANK_B_VOLT   = 6;
   localparam int         BIT_BANK_A_GFDIS  = 5;
   localparam int         BIT_BANK_B_GFDIS  = 4;
   localparam int         BIT_BANK_A_PWROFF = 3;
   localparam int         BIT_BANK_B_PWROFF = 2;
   localparam int         BIT_DIV_A_PWROFF  = 1;
   localparam int         BIT_DIV_B_PWROFF  = 0;
   // Timing at 20 MHz system clock
   localparam int         CLK_PERIOD_NS     = 50;
   localparam int         SCL_FAST_NS       = 2500;     // 400 kHz period
   localparam int         SCL_HALF_CYC      = (SCL_FAST_NS / 2) / CLK_PERIOD_NS;
   localparam logic [7:0] SCL_HALF_CNT      = 8'(SCL_HALF_CYC);
   // Host commands
   localparam logic [1:0] CMD_WRITE         = 2'h1;
   localparam logic [1:0] CMD_READ          = 2'h2;
endpackage : icps_pkg

// *** icps_ref_mux.sv ***
// Reference routing for the two output dividers
`timescale 1ns/1ps
`default_nettype none
module icps_ref_mux (
   input  wire logic       sel_source_i,    // 1: register field steers
   input  wire logic [1:0] ref_sel_i,       // Register selection field
   input  wire logic       select_pin_i,    // External select pin
   output logic            div_a_ref_one_o, // Divider A takes input one
   output logic            div_b_ref_one_o  // Divider B takes input one
);
   always_comb begin
      if (sel_source_i) begin
         div_a_ref_one_o = ref_sel_i[0];
         div_b_ref_one_o = ref_sel_i[1];
      end else begin
         div_a_ref_one_o = select_pin_i;
         div_b_ref_one_o = select_pin_i;
      end
   end
endmodule : icps_ref_mux
`default_nettype wire

// *** icps_slave.sv ***
// Two-wire slave configuration port with register file and input-select control
// Summary of operation
// - Slave only, up to fast rate
// - Answer address 110110 plus pin bit
// - First write byte sets register offset
// - Pointer increments per byte, MSB first
// - Stop after any byte is harmless
// - Each write byte committed at once
// - Block writes, reads via repeated start
// - Top bit selects glitch-free switching
// - Select field routes inputs to dividers
// - Source bit picks pin or field
// - Pin low input zero, high one
// - Sync bit holds dividers, release together
// - Bank disable tristates that bank
`timescale 1ns/1ps
`default_nettype none
module icps_slave
   import icps_pkg::*;
(
   input  wire logic       sys_clk_i,            // 20 MHz clock
   input  wire logic       rst_n_i,              // Sync reset, active low
   icps_link_if.slave      link,                 // Two-wire link
   input  wire logic       addr_lsb_pin_i,       // address_lsb_chip_select_pin
   input  wire logic       select_pin_i,         // External reference select
   output logic            switchover_mode_o,    // 1: glitch-free switch
   output logic            div_a_ref_one_o,      // Divider A on input one
   output logic            div_b_ref_one_o,      // Divider B on input one
   output logic            div_hold_o,           // Dividers held in reset
   output logic            div_sync_pulse_o,     // Joint release of dividers
   output logic            bank_a_hiz_o,         // Bank A outputs high-z
   output logic            bank_b_hiz_o,         // Bank B outputs high-z
   output logic [7:0]      bank_power_o          // Power and voltage bits
);
   import icps_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WBYTE, S_RBYTE, S_RACK, S_SKIP} icps_st_t;

   ////////////////////////////////////////////////////////////////////////////
   // Line sampling and start/stop detection
   logic [1:0] scl_q, scl_d, sda_q, sda_d;
   logic       scl_rise, scl_fall, start_det, stop_det;
   always_comb begin
      scl_d = {scl_q[0], link.scl};
      sda_d = {sda_q[0], link.sda};
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         scl_q <= 2'h3;
         sda_q <= 2'h3;
      end else begin
         scl_q <= scl_d;
         sda_q <= sda_d;
      end
   end
   assign scl_rise  = scl_q[0] && !scl_q[1];
   assign scl_fall  = !scl_q[0] && scl_q[1];
   assign start_det = scl_q[0] && scl_q[1] && sda_q[1] && !sda_q[0];
   assign stop_det  = scl_q[0] && scl_q[1] && !sda_q[1] && sda_q[0];

   ////////////////////////////////////////////////////////////////////////////
   // Protocol engine and register file
   icps_st_t   st_q, st_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
   logic [3:0] cnt_q, cnt_d;
   logic       rd_q, rd_d, have_ofs_q, have_ofs_d, addr_ph_q, addr_ph_d;
   logic       ack_q, ack_d, sda_oe_q, sda_oe_d;
   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] regs_d [NUM_REGS];

   function automatic logic [7:0] rd_byte(input logic [7:0] ofs, input logic [7:0] r0,
                                          input logic [7:0] r);
      if (ofs == OFS_INPUT_SELECT) rd_byte = r0 & MASK_INPUT_SELECT;
      else rd_byte = r;
   endfunction : rd_byte

   always_comb begin
      st_d       = st_q;
      sh_d       = sh_q;
      ptr_d      = ptr_q;
      cnt_d      = cnt_q;
      rd_d       = rd_q;
      have_ofs_d = have_ofs_q;
      addr_ph_d  = addr_ph_q;
      ack_d      = ack_q;
      sda_oe_d   = sda_oe_q;
      regs_d     = regs_q;
      if (start_det) begin
         st_d       = S_ADDR;                    // repeated start too
         cnt_d      = 4'h0;
         sda_oe_d   = 1'b0;
         have_ofs_d = 1'b0;
      end else if (stop_det) begin
         st_d     = S_IDLE;                      // writes already committed
         sda_oe_d = 1'b0;
      end else begin
         unique case (st_q)
            S_IDLE, S_SKIP: sda_oe_d = 1'b0;
            S_ADDR, S_WBYTE: begin
               if (scl_rise) begin
                  sh_d  = {sh_q[6:0], sda_q[0]};  // MSB first
                  cnt_d = cnt_q + 4'h1;
               end
               if (scl_fall && cnt_q == 4'h8) begin
                  addr_ph_d = (st_q == S_ADDR);
                  if (st_q == S_ADDR) begin
                     if (sh_q[7:1] == {DEV_ADDR_HI, addr_lsb_pin_i}) begin
                        rd_d     = sh_q[0];
                        sda_oe_d = 1'b1;
                        st_d     = S_ACK;
                     end else begin
                        st_d = S_SKIP;
                     end
                  end else begin
                     if (!have_ofs_q) begin
                        ptr_d      = sh_q;
                        have_ofs_d = 1'b1;
                     end else begin
                        if (ptr_q < 8'(NUM_REGS)) regs_d[ptr_q[3:0]] = sh_q;
                        ptr_d = ptr_q + 8'h01;
                     end
                     sda_oe_d = 1'b1;
                     st_d     = S_ACK;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (rd_q && addr_ph_q) begin
                     sh_d     = (ptr_q < 8'(NUM_REGS)) ?
                                rd_byte(ptr_q, regs_q[0], regs_q[ptr_q[3:0]]) : 8'h00;
                     sda_oe_d = !sh_d[7];
                     st_d     = S_RBYTE;
                  end else begin
                     sda_oe_d = 1'b0;
                     st_d     = S_WBYTE;
                  end
               end
            end
            S_RBYTE: begin
               if (scl_fall) begin
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     sda_oe_d = 1'b0;
                     st_d     = S_RACK;
                     ptr_d    = ptr_q + 8'h01;
                  end else begin
                     sh_d     = {sh_q[6:0], 1'b0};
                     sda_oe_d = !sh_d[7];
                  end
               end
            end
            S_RACK: begin
               if (scl_rise) ack_d = !sda_q[0];  // master nack ends read
               if (scl_fall) begin
                  addr_ph_d = 1'b1;
                  st_d      = ack_q ? S_ACK : S_SKIP;
                  if (ack_q) begin
                     sh_d     = (ptr_q < 8'(NUM_REGS)) ?
                                rd_byte(ptr_q, regs_q[0], regs_q[ptr_q[3:0]]) : 8'h00;
                     sda_oe_d = !sh_d[7];
                     cnt_d    = 4'h0;
                     st_d     = S_RBYTE;
                  end
               end
            end
            default: st_d = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_q       <= S_IDLE;
         sh_q       <= 8'h00;
         ptr_q      <= 8'h00;
         cnt_q      <= 4'h0;
         rd_q       <= 1'b0;
         have_ofs_q <= 1'b0;
         addr_ph_q  <= 1'b0;
         ack_q      <= 1'b0;
         sda_oe_q   <= 1'b0;
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= 8'h00;
         end
         regs_q[0]  <= RST_INPUT_SELECT;
         regs_q[1]  <= RST_BANK_POWER;
      end else begin
         st_q       <= st_d;
         sh_q       <= sh_d;
         ptr_q      <= ptr_d;
         cnt_q      <= cnt_d;
         rd_q       <= rd_d;
         have_ofs_q <= have_ofs_d;
         addr_ph_q  <= addr_ph_d;
         ack_q      <= ack_d;
         sda_oe_q   <= sda_oe_d;
         regs_q     <= regs_d;
      end
   end
   assign link.sda_s_o  = 1'b0;                  // open drain, never drives clock
   assign link.sda_s_oe = sda_oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Control outputs
   logic       mux_a, mux_b;
   logic       sync_q, sync_d;
   logic [7:0] cfg0, cfg1;
   logic [12:0] out_q, out_d;
   assign cfg0 = regs_q[0];
   assign cfg1 = regs_q[1];
   icps_ref_mux u_mux (
      .sel_source_i    (cfg0[BIT_SEL_SOURCE]),
      .ref_sel_i       ({cfg0[BIT_REF_SEL_HI], cfg0[BIT_REF_SEL_LO]}),
      .select_pin_i    (select_pin_i),
      .div_a_ref_one_o (mux_a),
      .div_b_ref_one_o (mux_b)
   );
   always_comb begin
      sync_d = cfg0[BIT_DIV_SYNC];
      out_d  = {cfg0[BIT_SWITCH_MODE],
                mux_a, mux_b,
                cfg0[BIT_DIV_SYNC],                     // hold
                sync_q && !cfg0[BIT_DIV_SYNC],          // 1->0 release
                cfg1[BIT_BANK_A_GFDIS],
                cfg1[BIT_BANK_B_GFDIS],
                cfg1[BIT_BANK_A_VOLT], cfg1[BIT_BANK_B_VOLT],
                cfg1[BIT_DIV_A_PWROFF], cfg1[BIT_DIV_B_PWROFF],
                cfg1[BIT_BANK_A_PWROFF], cfg1[BIT_BANK_B_PWROFF]};
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sync_q <= 1'b0;
         out_q  <= 13'h0000;
      end else begin
         sync_q <= sync_d;
         out_q  <= out_d;
      end
   end
   assign switchover_mode_o = out_q[12];
   assign div_a_ref_one_o   = out_q[11];
   assign div_b_ref_one_o   = out_q[10];
   assign div_hold_o        = out_q[9];
   assign div_sync_pulse_o  = out_q[8];
   assign bank_a_hiz_o      = out_q[7];
   assign bank_b_hiz_o      = out_q[6];
   assign bank_power_o      = {out_q[5], out_q[4], out_q[7], out_q[6],
                               out_q[1], out_q[0], out_q[3], out_q[2]};
endmodule : icps_slave
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: APB commands into the master end, slave outputs observed
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import icps_pkg::*;
   typedef struct {
      logic [7:0]  ofs;
      logic [7:0]  data;
      logic        sel;
      logic [13:0] exp;
   } icps_row_t;
   logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [3:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        addr_pin, sel_pin, sw, div_a, div_b, hold, pulse, hiz_a, hiz_b;
   logic [7:0]  power;
   logic        rd_cmd;
   logic [13:0] obs;
   int          num_errors, total_checks, sync_pulses;
   icps_row_t   rows[9];
   icps_link_if link ();
   assign obs = {sw, div_a, div_b, hold, hiz_a, hiz_b, power};
   icps_master icps_master_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(link),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   icps_slave icps_slave_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(link),
      .addr_lsb_pin_i(addr_pin), .select_pin_i(sel_pin), .switchover_mode_o(sw),
      .div_a_ref_one_o(div_a), .div_b_ref_one_o(div_b), .div_hold_o(hold),
      .div_sync_pulse_o(pulse), .bank_a_hiz_o(hiz_a), .bank_b_hiz_o(hiz_b),
      .bank_power_o(power));
   icps_link_monitor icps_link_monitor_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe),
      .scl(link.scl), .sda(link.sda));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (pulse === 1'b1) begin
         sync_pulses <= sync_pulses + 1;
      end
   end
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         num_errors++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   // One command over the link, a one-byte write unless rd_cmd is set, then wait for the busy flag to clear
   task automatic xfer(input logic [7:0] ofs, input logic [7:0] data, input logic lsb);
      int n;
      apb(1'b1, 4'h4, {24'h0, data});
      apb(1'b1, 4'h0, {20'h0, lsb, 1'b0, 1'b1, rd_cmd, ofs});
      n = 0;
      do begin
         apb(1'b0, 4'h0, 32'h0);
         n++;
      end while (rd[9] !== 1'b0 && n < 2000);
      if (rd[9] !== 1'b0) begin
         num_errors++;
         give_verdict();
      end
      repeat (4) @(posedge sys_clk);
   endtask : xfer
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 4'h0;
      pwdata = 32'h0;
      addr_pin = 1'b1;
      sel_pin = 1'b0;
      rd_cmd = 1'b0;
      num_errors = 0;
      total_checks = 0;
      sync_pulses = 0;
      rows = '{'{8'h00, 8'h80, 1'b1, 14'h3800}, '{8'h00, 8'h10, 1'b1, 14'h0000},
               '{8'h00, 8'h30, 1'b0, 14'h1000}, '{8'h00, 8'h50, 1'b0, 14'h0800},
               '{8'h00, 8'h70, 1'b0, 14'h1800}, '{8'h00, 8'h00, 1'b0, 14'h0000},
               '{8'h01, 8'hFF, 1'b0, 14'h03FF}, '{8'h01, 8'h20, 1'b1, 14'h1A20},
               '{8'h00, 8'h81, 1'b0, 14'h2620}};
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check(obs, 14'h0000);
      check({link.scl, link.sda}, 2'b11);
      foreach (rows[i]) begin
         sel_pin <= rows[i].sel;
         xfer(rows[i].ofs, rows[i].data, 1'b1);
         check(obs, rows[i].exp);
         check(rd[10], 1'b0);
      end
      check(sync_pulses, 0);
      // Wrong last address bit: no answer, nothing changes
      xfer(8'h00, 8'h00, 1'b0);
      check(rd[10], 1'b1);
      check(obs, 14'h2620);
      addr_pin <= 1'b0;
      xfer(8'h00, 8'h00, 1'b0);
      check(rd[10], 1'b0);
      check(obs, 14'h0220);
      check(sync_pulses, 1);
      // Read command stops after the offset: pointer set, nothing written
      rd_cmd = 1'b1;
      xfer(8'h01, 8'hFF, 1'b0);
      rd_cmd = 1'b0;
      check(rd[10], 1'b0);
      check(obs, 14'h0220);
      apb(1'b1, 4'h4, 32'h000000A5);
      apb(1'b0, 4'h4, 32'h0);
      check(rd[7:0], 8'hA5);
      apb(1'b0, 4'h8, 32'h0);
      check(err, 1'b0);
      // Reset in mid-run clears every control bit
      rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check(obs, 14'h0000);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
